/* File: ppc_pixel_port.sv */
`timescale 1ns/1ns
module ppc_pixel_port (
   input  wire logic                                    CLK,
   input  wire logic                                    SRST,
   input  wire logic [3:0]                              COLOR_MODE_FIELD,
   input  wire logic                                    LOOKUP_WIDTH_SELECT,
   input  wire logic                                    OCTAL_MUX_SELECT_HI,
   input  wire logic                                    OCTAL_MUX_SELECT_LO,
   input  wire logic                                    PER_PIXEL_BYPASS_EN,
   input  wire logic                                    PIXEL_LATCH_STROBE,
   input  wire ppc_pkg::ppc_rgb8_t [ppc_pkg::NUM_BANKS-1:0] PIXEL_BANKS,
   input  wire logic [ppc_pkg::NUM_BANKS-1:0][1:0]      PALETTE_SELECT_INPUTS,
   input  wire ppc_pkg::ppc_vctrl_t                     VIDEO_CTRL,
   input  wire ppc_pkg::ppc_rgb10_t                     LUT_DATA,
   output logic                                         LOAD_CLOCK_OUTPUT,
   output ppc_pkg::ppc_rgb8_t                           LUT_ADDR,
   output logic                                         LUT_READ,
   output logic [1:0]                                   PIXEL_SELECT_OUT,
   output ppc_pkg::ppc_rgb10_t                          DAC_DATA,
   output ppc_pkg::ppc_vctrl_t                          DAC_CTRL,
   output logic                                         DAC_VALID
);
   import ppc_pkg::*;

   //------------------------------------------------------------------
   // decode helpers
   //------------------------------------------------------------------
   // the octal select overrides the colour mode field entirely
   function automatic ppc_mode_t decode_mode(input logic [3:0] cm, input logic [1:0] msel);
      ppc_mode_t m;
      m = PPC_PSEUDO_R;
      if (msel == MUX_SEL_8TO1) begin
         m = PPC_PSEUDO_G;
      end else begin
         case (cm)
            CM_PSEUDO_RED:   m = PPC_PSEUDO_R;
            CM_PSEUDO_GREEN: m = PPC_PSEUDO_G;
            CM_PSEUDO_BLUE:  m = PPC_PSEUDO_B;
            CM_TRUE16:       m = PPC_TRUE16;
            CM_TRUE15_RGB:   m = PPC_TRUE15_RGB;
            CM_TRUE15_RG:    m = PPC_TRUE15_RG;
            CM_TRUE24:       m = PPC_TRUE24;
            CM_BYPASS16:     m = PPC_BYP16;
            CM_BYPASS15:     m = PPC_BYP15;
            CM_BYPASS24:     m = PPC_BYP24;
            default:         m = PPC_PSEUDO_R;
         endcase
      end
      return m;
   endfunction

   function automatic logic [3:0] ratio_of(input logic [1:0] msel);
      logic [3:0] r;
      r = RATIO_4;
      case (msel)
         MUX_SEL_8TO1: r = RATIO_8;
         MUX_SEL_2TO1: r = RATIO_2;
         default:      r = RATIO_4;
      endcase
      return r;
   endfunction

   logic [1:0]  mux_sel;
   ppc_mode_t   mode;
   logic [3:0]  ratio;
   logic        octal;

   assign mux_sel = {OCTAL_MUX_SELECT_HI, OCTAL_MUX_SELECT_LO};
   assign mode    = decode_mode(COLOR_MODE_FIELD, mux_sel);
   assign ratio   = ratio_of(mux_sel);
   assign octal   = (mux_sel == MUX_SEL_8TO1);

   //------------------------------------------------------------------
   // load clock divider
   //------------------------------------------------------------------
   logic [3:0] div_q;
   logic       load_q;

   // high for the first half of each group, one period per latch group
   always_ff @(posedge CLK) begin
      if (SRST) begin
         div_q  <= 4'h0;
         load_q <= 1'b0;
      end else begin
         if (div_q >= ratio - 4'h1) begin
            div_q <= 4'h0;
         end else begin
            div_q <= div_q + 4'h1;
         end
         load_q <= (div_q < (ratio >> 1));
      end
   end
   assign LOAD_CLOCK_OUTPUT = load_q;

   //------------------------------------------------------------------
   // latch strobe capture
   //------------------------------------------------------------------
   // the strobe is taken as synchronous; the edge is found by comparison
   // with last cycle, so it must come at a whole division of the clock
   logic                                       strobe_q;
   logic                                       latch_ev;
   ppc_rgb8_t [NUM_BANKS-1:0]                  bank_q;
   logic [NUM_BANKS-1:0][1:0]                  ps_q;
   ppc_vctrl_t                                 ctrl_q;
   logic                                       primed_q;

   assign latch_ev = PIXEL_LATCH_STROBE & ~strobe_q;

   always_ff @(posedge CLK) begin
      if (SRST) begin
         strobe_q <= 1'b0;
      end else begin
         strobe_q <= PIXEL_LATCH_STROBE;
      end
   end

   // every bank, select and control input is caught on the same edge
   always_ff @(posedge CLK) begin
      if (SRST) begin
         bank_q   <= '0;
         ps_q     <= '0;
         ctrl_q   <= '{blank_n: 1'b0, sync_n: 1'b1, odd_even: 1'b0, tri_sync: 1'b0};
         primed_q <= 1'b0;
      end else if (latch_ev) begin
         bank_q   <= PIXEL_BANKS;
         ps_q     <= PALETTE_SELECT_INPUTS;
         ctrl_q   <= VIDEO_CTRL;
         primed_q <= 1'b1;
      end
   end

   //------------------------------------------------------------------
   // serialiser index
   //------------------------------------------------------------------
   logic [2:0] idx_q;

   // each latch restarts the sequence at pixel A
   always_ff @(posedge CLK) begin
      if (SRST) begin
         idx_q <= 3'h0;
      end else if (latch_ev) begin
         idx_q <= 3'h0;
      end else if ({1'b0, idx_q} >= ratio - 4'h1) begin
         idx_q <= 3'h0;
      end else begin
         idx_q <= idx_q + 3'h1;
      end
   end

   //------------------------------------------------------------------
   // pixel selection
   //------------------------------------------------------------------
   ppc_rgb8_t  pix;
   logic [7:0] octal_byte;
   ppc_rgb8_t  octal_bank;
   logic [1:0] pix_ps;

   // octal order alternates green then red of each bank, A to D
   always_comb begin
      octal_bank = bank_q[idx_q[2:1]];
      octal_byte = idx_q[0] ? octal_bank.red : octal_bank.green;
      pix        = bank_q[idx_q[1:0]];
      pix_ps     = ps_q[idx_q[1:0]];
      if (octal) begin
         pix_ps = idx_q[0] ? octal_bank.blue[3:2] : octal_bank.blue[1:0];
      end
   end

   //------------------------------------------------------------------
   // address and bypass mapping
   //------------------------------------------------------------------
   ppc_rgb8_t  addr_d;
   ppc_rgb10_t byp_d;
   logic       bypass_d;

   always_comb begin
      addr_d   = '0;
      byp_d    = '0;
      bypass_d = 1'b0;
      case (mode)
         PPC_PSEUDO_R: begin
            addr_d = '{red: pix.red, green: pix.red, blue: pix.red};
         end
         PPC_PSEUDO_G: begin
            if (octal) begin
               addr_d = '{red: octal_byte, green: octal_byte, blue: octal_byte};
            end else begin
               addr_d = '{red: pix.green, green: pix.green, blue: pix.green};
            end
         end
         PPC_PSEUDO_B: begin
            addr_d = '{red: pix.blue, green: pix.blue, blue: pix.blue};
         end
         PPC_TRUE24: begin
            addr_d = pix;
         end
         PPC_TRUE16: begin
            // red and green bytes form one 16-bit word, blue ignored
            addr_d.red   = {3'h0, pix.red[7:3]};
            addr_d.green = {2'h0, pix.red[2:0], pix.green[7:5]};
            addr_d.blue  = {3'h0, pix.green[4:0]};
         end
         PPC_TRUE15_RGB: begin
            addr_d.red   = {3'h0, pix.red[7:3]};
            addr_d.green = {3'h0, pix.green[7:3]};
            addr_d.blue  = {3'h0, pix.blue[7:3]};
         end
         PPC_TRUE15_RG: begin
            addr_d.red   = {3'h0, pix.red[6:2]};
            addr_d.green = {3'h0, pix.red[1:0], pix.green[7:5]};
            addr_d.blue  = {3'h0, pix.green[4:0]};
         end
         PPC_BYP16: begin
            bypass_d     = 1'b1;
            byp_d.red    = {pix.red[7:3], 5'h00};
            byp_d.green  = {pix.red[2:0], pix.green[7:5], 4'h0};
            byp_d.blue   = {pix.green[4:0], 5'h00};
         end
         PPC_BYP15: begin
            bypass_d     = 1'b1;
            byp_d.red    = {pix.red[6:2], 5'h00};
            byp_d.green  = {pix.red[1:0], pix.green[7:5], 5'h00};
            byp_d.blue   = {pix.green[4:0], 5'h00};
         end
         PPC_BYP24: begin
            bypass_d = 1'b1;
            byp_d    = '{red: {pix.red, 2'h0}, green: {pix.green, 2'h0},
                         blue: {pix.blue, 2'h0}};
         end
         default: begin
            addr_d = '0;
         end
      endcase
      // per-pixel bypass of a 24-bit pixel, only where the package has it
      if (PER_PIXEL_BYPASS_EN && !octal && mode == PPC_TRUE24 && pix_ps == PS_BYPASS) begin
         bypass_d = 1'b1;
         byp_d    = '{red: {pix.red, 2'h0}, green: {pix.green, 2'h0},
                      blue: {pix.blue, 2'h0}};
      end
   end

   //------------------------------------------------------------------
   // stage 1: lookup address out, bypass value held alongside
   //------------------------------------------------------------------
   ppc_rgb8_t  addr_q;
   ppc_rgb10_t byp_q;
   logic       bypass_q;
   logic       rd_q;
   logic [1:0] psel_q;
   ppc_vctrl_t ctrl1_q;
   logic       width10_q;

   // bypass pixels skip the palette, so no read is issued for them;
   // nothing counts as a pixel before the first latch, bypass included
   always_ff @(posedge CLK) begin
      if (SRST) begin
         addr_q    <= '0;
         byp_q     <= '0;
         bypass_q  <= 1'b0;
         rd_q      <= 1'b0;
         psel_q    <= 2'h0;
         ctrl1_q   <= '{blank_n: 1'b0, sync_n: 1'b1, odd_even: 1'b0, tri_sync: 1'b0};
         width10_q <= 1'b0;
      end else begin
         addr_q    <= bypass_d ? '0 : addr_d;
         byp_q     <= byp_d;
         bypass_q  <= primed_q & bypass_d;
         rd_q      <= primed_q & ~bypass_d;
         psel_q    <= pix_ps;
         ctrl1_q   <= ctrl_q;
         width10_q <= LOOKUP_WIDTH_SELECT;
      end
   end
   assign LUT_ADDR         = addr_q;
   assign LUT_READ         = rd_q;
   assign PIXEL_SELECT_OUT = psel_q;

   //------------------------------------------------------------------
   // stage 2: DAC word, palette data arrives in the same cycle as the address
   //------------------------------------------------------------------
   ppc_rgb10_t dac_q;
   ppc_vctrl_t dctrl_q;
   logic       dvalid_q;

   // an 8-bit entry fills the top of the DAC input; a 10-bit one all of it
   always_ff @(posedge CLK) begin
      if (SRST) begin
         dac_q    <= '0;
         dctrl_q  <= '{blank_n: 1'b0, sync_n: 1'b1, odd_even: 1'b0, tri_sync: 1'b0};
         dvalid_q <= 1'b0;
      end else begin
         if (bypass_q) begin
            dac_q <= byp_q;
         end else if (width10_q) begin
            dac_q <= LUT_DATA;
         end else begin
            dac_q <= '{red: {LUT_DATA.red[7:0], 2'h0},
                       green: {LUT_DATA.green[7:0], 2'h0},
                       blue: {LUT_DATA.blue[7:0], 2'h0}};
         end
         dctrl_q  <= ctrl1_q;
         dvalid_q <= rd_q | bypass_q;
      end
   end
   assign DAC_DATA  = dac_q;
   assign DAC_CTRL  = dctrl_q;
   assign DAC_VALID = dvalid_q;

endmodule

/* File: ppc_pkg.sv */
//------------------------------------------------------------------
//------------------------------------------------------------------
package ppc_pkg;

   //------------------------------------------------------------------
   // colour mode field codes
   //------------------------------------------------------------------
   localparam logic [3:0] CM_PSEUDO_RED   = 4'h0;
   localparam logic [3:0] CM_PSEUDO_GREEN = 4'h4;
   localparam logic [3:0] CM_PSEUDO_BLUE  = 4'h8;
   localparam logic [3:0] CM_TRUE16       = 4'hB;
   localparam logic [3:0] CM_TRUE15_RGB   = 4'hC;
   localparam logic [3:0] CM_TRUE15_RG    = 4'hD;
   localparam logic [3:0] CM_TRUE24       = 4'hE;
   localparam logic [3:0] CM_BYPASS16     = 4'h9;
   localparam logic [3:0] CM_BYPASS15     = 4'hA;
   localparam logic [3:0] CM_BYPASS24     = 4'hF;

   //------------------------------------------------------------------
   // multiplex select codes {hi, lo} and ratios
   //------------------------------------------------------------------
   localparam logic [1:0] MUX_SEL_8TO1 = 2'h2;
   localparam logic [1:0] MUX_SEL_2TO1 = 2'h1;
   localparam logic [3:0] RATIO_2      = 4'h2;
   localparam logic [3:0] RATIO_4      = 4'h4;
   localparam logic [3:0] RATIO_8      = 4'h8;

   // palette select value that requests per-pixel bypass
   localparam logic [1:0] PS_BYPASS    = 2'h3;
   localparam int         NUM_BANKS    = 4;

   typedef enum {
      PPC_PSEUDO_R, PPC_PSEUDO_G, PPC_PSEUDO_B, PPC_TRUE24, PPC_TRUE16,
      PPC_TRUE15_RGB, PPC_TRUE15_RG, PPC_BYP24, PPC_BYP16, PPC_BYP15
   } ppc_mode_t;

   typedef struct packed {
      logic [7:0] red;
      logic [7:0] green;
      logic [7:0] blue;
   } ppc_rgb8_t;

   typedef struct packed {
      logic [9:0] red;
      logic [9:0] green;
      logic [9:0] blue;
   } ppc_rgb10_t;

   typedef struct packed {
      logic blank_n;
      logic sync_n;
      logic odd_even;
      logic tri_sync;
   } ppc_vctrl_t;

endpackage

/* File: ppc_pixel_port_assertions.sv */
`timescale 1ns/1ns
//------------------------------------------------------------
// pixel port checker
//------------------------------------------------------------
module ppc_pixel_port_checker (
   input wire logic                CLK,
   input wire logic                SRST,
   input wire logic [3:0]          COLOR_MODE_FIELD,
   input wire logic                LOOKUP_WIDTH_SELECT,
   input wire logic                OCTAL_MUX_SELECT_HI,
   input wire logic                OCTAL_MUX_SELECT_LO,
   input wire logic                PIXEL_LATCH_STROBE,
   input wire logic                LOAD_CLOCK_OUTPUT,
   input wire logic                LUT_READ,
   input wire ppc_pkg::ppc_rgb10_t DAC_DATA,
   input wire ppc_pkg::ppc_vctrl_t DAC_CTRL,
   input wire logic                DAC_VALID
);
   import ppc_pkg::*;
   logic       strb_q;
   logic [2:0] rise_q;
   wire logic  lco  = LOAD_CLOCK_OUTPUT;
   wire logic  sel8 = ({OCTAL_MUX_SELECT_HI, OCTAL_MUX_SELECT_LO} == MUX_SEL_8TO1);
   wire logic  sel2 = ({OCTAL_MUX_SELECT_HI, OCTAL_MUX_SELECT_LO} == MUX_SEL_2TO1);
   wire logic  byp  = (COLOR_MODE_FIELD == CM_BYPASS24) || (COLOR_MODE_FIELD == CM_BYPASS16)
                      || (COLOR_MODE_FIELD == CM_BYPASS15);
   // latch edge history, three deep so it lines up with the output stage
   always_ff @(posedge CLK) begin
      if (SRST) begin
         strb_q <= 1'b0;
         rise_q <= 3'h0;
      end else begin
         strb_q <= PIXEL_LATCH_STROBE;
         rise_q <= {rise_q[1:0], PIXEL_LATCH_STROBE & ~strb_q};
      end
   end
   default clocking cb @(posedge CLK); endclocking
   default disable iff (SRST);
   property p_lclk4;
      ($rose(lco) && !sel8 && !sel2) |=> lco ##1 !lco [*2] ##1 lco;
   endproperty
   a_lclk4: assert property (p_lclk4) else $error("load clock period not 4");
   property p_lclk2;
      ($rose(lco) && sel2) |=> !lco ##1 lco;
   endproperty
   a_lclk2: assert property (p_lclk2) else $error("load clock period not 2");
   property p_lclk8;
      ($rose(lco) && sel8) |=> lco [*3] ##1 !lco [*4] ##1 lco;
   endproperty
   a_lclk8: assert property (p_lclk8) else $error("load clock period not 8");
   property p_lut_dac;
      LUT_READ |=> DAC_VALID;
   endproperty
   a_lut_dac: assert property (p_lut_dac) else $error("lookup without dac word");
   property p_w8_low;
      (DAC_VALID && !LOOKUP_WIDTH_SELECT) |-> (DAC_DATA.red[1:0] == 2'h0) && (DAC_DATA.green[1:0] == 2'h0)
         && (DAC_DATA.blue[1:0] == 2'h0);
   endproperty
   a_w8_low: assert property (p_w8_low) else $error("low dac bits set in 8-bit width");
   property p_byp_noread;
      (byp && !sel8) |-> !LUT_READ;
   endproperty
   a_byp_noread: assert property (p_byp_noread) else $error("palette read in bypass");
   property p_latch_dac;
      $rose(PIXEL_LATCH_STROBE) |-> ##3 DAC_VALID;
   endproperty
   a_latch_dac: assert property (p_latch_dac) else $error("latched group not shown");
   property p_ctrl_latch;
      // the reset value loading is not a group boundary
      ($changed(DAC_CTRL) && !$past(SRST)) |-> rise_q[2];
   endproperty
   a_ctrl_latch: assert property (p_ctrl_latch) else $error("control changed inside group");
endmodule

bind ppc_pixel_port ppc_pixel_port_checker u_chk (.CLK(CLK), .SRST(SRST), .COLOR_MODE_FIELD(COLOR_MODE_FIELD),
   .LOOKUP_WIDTH_SELECT(LOOKUP_WIDTH_SELECT), .OCTAL_MUX_SELECT_HI(OCTAL_MUX_SELECT_HI),
   .OCTAL_MUX_SELECT_LO(OCTAL_MUX_SELECT_LO), .PIXEL_LATCH_STROBE(PIXEL_LATCH_STROBE),
   .LOAD_CLOCK_OUTPUT(LOAD_CLOCK_OUTPUT), .LUT_READ(LUT_READ), .DAC_DATA(DAC_DATA), .DAC_CTRL(DAC_CTRL),
   .DAC_VALID(DAC_VALID));

/* File: ppc_mem_model.sv */
`timescale 1ns/1ns
//------------------------------------------------------------
// memory side: latch strobe loop-back and palette contents
//------------------------------------------------------------
module ppc_mem_model (
   input  wire logic               CLK,
   input  wire logic               LOAD_CLOCK_OUTPUT,
   input  wire ppc_pkg::ppc_rgb8_t LUT_ADDR,
   input  wire logic               LUT_READ,
   output logic                    PIXEL_LATCH_STROBE,
   output ppc_pkg::ppc_rgb10_t     LUT_DATA
);
   import ppc_pkg::*;
   logic [29:0] idle_q = 30'h0;
   // strobe is the load clock looped straight back, an exact divide of the clock
   assign PIXEL_LATCH_STROBE = LOAD_CLOCK_OUTPUT;
   // data not being read flips every cycle so a stale sample cannot match
   always_ff @(posedge CLK) begin
      idle_q <= ~idle_q;
   end
   // each entry tags its colour in the top bits so swapped channels show
   assign LUT_DATA = LUT_READ ? {2'h2, LUT_ADDR.red, 2'h1, LUT_ADDR.green, 2'h3, LUT_ADDR.blue} : idle_q;
endmodule

/* File: ppc_pixel_port_tb_top.sv */
`timescale 1ns/1ns
module ppc_pixel_port_tb_top;
   import ppc_pkg::*;
   //------------------------------------------------------------
   // stimulus, instances and checks
   //------------------------------------------------------------
   logic                      clk    = 1'b0;
   logic                      srst   = 1'b1;
   logic [3:0]                mode   = 4'h0;
   logic                      wsel   = 1'b0;
   logic [1:0]                msel   = 2'h0;
   logic                      byp_en = 1'b0;
   ppc_rgb8_t [NUM_BANKS-1:0] banks  = {24'h7E18E7, 24'h0FF081, 24'h5AC369, 24'hA53C96};
   logic [NUM_BANKS-1:0][1:0] psel   = 8'h1D;
   ppc_vctrl_t                vctrl  = 4'h4;
   logic                      strobe, lco, lut_rd, dvalid;
   logic [1:0]                sel_out;
   ppc_rgb8_t                 lut_addr;
   ppc_rgb10_t                lut_data, dac;
   ppc_vctrl_t                dctrl;
   int                        failures = 0;
   int                        total_checks = 0;
   ppc_rgb10_t                pix_q[$];
   logic [1:0]                sel_q[$];
   logic [3:0]                codes [11] = '{CM_PSEUDO_RED, CM_PSEUDO_GREEN, CM_PSEUDO_BLUE, CM_TRUE16,
      CM_TRUE15_RGB, CM_TRUE15_RG, CM_TRUE24, CM_BYPASS24, CM_BYPASS16, CM_BYPASS15, 4'h3};

   always #50 clk = ~clk;

   ppc_pixel_port dut (.CLK(clk), .SRST(srst), .COLOR_MODE_FIELD(mode), .LOOKUP_WIDTH_SELECT(wsel),
      .OCTAL_MUX_SELECT_HI(msel[1]), .OCTAL_MUX_SELECT_LO(msel[0]), .PER_PIXEL_BYPASS_EN(byp_en),
      .PIXEL_LATCH_STROBE(strobe), .PIXEL_BANKS(banks), .PALETTE_SELECT_INPUTS(psel), .VIDEO_CTRL(vctrl),
      .LUT_DATA(lut_data), .LOAD_CLOCK_OUTPUT(lco), .LUT_ADDR(lut_addr), .LUT_READ(lut_rd),
      .PIXEL_SELECT_OUT(sel_out), .DAC_DATA(dac), .DAC_CTRL(dctrl), .DAC_VALID(dvalid));
   ppc_mem_model u_mem (.CLK(clk), .LOAD_CLOCK_OUTPUT(lco), .LUT_ADDR(lut_addr), .LUT_READ(lut_rd),
      .PIXEL_LATCH_STROBE(strobe), .LUT_DATA(lut_data));

   // record the output stream; selects follow the lookup stage
   always @(posedge clk) begin
      if (dvalid === 1'b1) pix_q.push_back(dac);
      if (lut_rd === 1'b1) sel_q.push_back(sel_out);
   end

   // palette word the memory model returns, cut to 8 bits when narrow
   function automatic ppc_rgb10_t lut_of(input ppc_rgb8_t a, input logic w);
      ppc_rgb10_t v;
      v = {2'h2, a.red, 2'h1, a.green, 2'h3, a.blue};
      if (!w) v = {v.red[7:0], 2'h0, v.green[7:0], 2'h0, v.blue[7:0], 2'h0};
      return v;
   endfunction

   function automatic ppc_rgb10_t expect_pix(input logic [3:0] m, input logic w, input ppc_rgb8_t p,
                                             input logic byp);
      ppc_rgb8_t a;
      a = {p.red, p.red, p.red};
      if (byp) return {p.red, 2'h0, p.green, 2'h0, p.blue, 2'h0};
      case (m)
         CM_PSEUDO_GREEN: a = {p.green, p.green, p.green};
         CM_PSEUDO_BLUE:  a = {p.blue, p.blue, p.blue};
         CM_TRUE16:       a = {3'h0, p.red[7:3], 2'h0, p.red[2:0], p.green[7:5], 3'h0, p.green[4:0]};
         CM_TRUE15_RGB:   a = {3'h0, p.red[7:3], 3'h0, p.green[7:3], 3'h0, p.blue[7:3]};
         CM_TRUE15_RG:    a = {3'h0, p.red[6:2], 3'h0, p.red[1:0], p.green[7:5], 3'h0, p.green[4:0]};
         CM_TRUE24:       a = p;
         CM_BYPASS24:     return {p.red, 2'h0, p.green, 2'h0, p.blue, 2'h0};
         CM_BYPASS16:     return {p.red[7:3], 5'h0, p.red[2:0], p.green[7:5], 4'h0, p.green[4:0], 5'h0};
         CM_BYPASS15:     return {p.red[6:2], 5'h0, p.red[1:0], p.green[7:5], 5'h0, p.green[4:0], 5'h0};
         default: ;
      endcase
      return lut_of(a, w);
   endfunction

   task automatic note_fail(input string s);
      failures++;
      $display("MISMATCH t=%0t %s", $time, s);
   endtask

   task automatic check_pix(input ppc_rgb10_t g, input ppc_rgb10_t e);
      total_checks++;
      if (g !== e) note_fail($sformatf("pixel %h expected %h", g, e));
   endtask

   task automatic check_sel(input logic [1:0] g, input logic [1:0] e);
      total_checks++;
      if (g !== e) note_fail($sformatf("select %h expected %h", g, e));
   endtask

   task automatic check_ctrl(input ppc_vctrl_t g, input ppc_vctrl_t e);
      total_checks++;
      if (g !== e) note_fail($sformatf("control %h expected %h", g, e));
   endtask

   task automatic summarize();
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // configuration only moves under reset, so the first word out is pixel A
   task automatic run(input logic [3:0] m, input logic w, input logic [1:0] ms, input logic be);
      int         r;
      int         n;
      logic [7:0] b;
      logic       pb;
      r = (ms == MUX_SEL_8TO1) ? 8 : (ms == MUX_SEL_2TO1) ? 2 : 4;
      @(posedge clk);
      srst   <= 1'b1;
      // settings move one edge after reset is seen, never together with it
      @(posedge clk);
      mode   <= m;
      wsel   <= w;
      msel   <= ms;
      byp_en <= be;
      vctrl  <= {2'h3, m[1:0]};
      repeat (2) @(posedge clk);
      pix_q.delete();
      sel_q.delete();
      srst <= 1'b0;
      for (n = 0; n < 200 && pix_q.size() < 2 * r; n++) @(posedge clk);
      if (pix_q.size() < 2 * r) begin
         note_fail("pixel stream stalled");
         summarize();
      end else begin
         for (n = 0; n < 2 * r; n++) begin
            if (r == 8) begin
               b = (n % 2 == 0) ? banks[(n % 8) / 2].green : banks[(n % 8) / 2].red;
               check_pix(pix_q[n], expect_pix(CM_PSEUDO_RED, w, {b, b, b}, 1'b0));
               check_sel(sel_q[n], banks[(n % 8) / 2].blue[(n % 2) * 2 +: 2]);
            end else begin
               pb = be && psel[n % r] == PS_BYPASS && m == CM_TRUE24;
               check_pix(pix_q[n], expect_pix(m, w, banks[n % r], pb));
               if (!be && sel_q.size() > n) check_sel(sel_q[n], psel[n % r]);
            end
         end
         check_ctrl(dctrl, {2'h3, m[1:0]});
      end
   endtask

   initial begin
      int i;
      repeat (12) @(posedge clk);
      check_ctrl(dctrl, 4'h4);
      for (i = 0; i < 11; i++) begin
         run(codes[i], i[0], 2'h0, 1'b0);
      end
      run(CM_TRUE24, 1'b1, 2'h3, 1'b1);
      run(CM_TRUE15_RG, 1'b0, MUX_SEL_2TO1, 1'b0);
      run(CM_TRUE24, 1'b0, MUX_SEL_8TO1, 1'b0);
      summarize();
   end
endmodule
